// File: hdl/swkcr_defs.svh
// register addresses, reset values and field positions
`ifndef SWKCR_DEFS_SVH
`define SWKCR_DEFS_SVH
`define SWKCR_ADDR_SCR_LO 7'h1e
`define SWKCR_ADDR_SCR_HI 7'h1f
`define SWKCR_ADDR_CTRL 7'h20
`define SWKCR_ADDR_QUANTA 7'h21
`define SWKCR_ADDR_SPOINT 7'h22
`define SWKCR_ADDR_IDTOP 7'h23
`define SWKCR_ADDR_OPTION 7'h2c
`define SWKCR_ADDR_CFG_LO 7'h23
`define SWKCR_ADDR_CFG_HI 7'h2b
`define SWKCR_RST_SCR 8'h00
`define SWKCR_RST_CTRL 8'h00
`define SWKCR_RST_QUANTA 8'ha0
`define SWKCR_RST_SPOINT 8'h33
`define SWKCR_RST_IDTOP 8'h00
`define SWKCR_BIT_OSCILLATOR_CALIBRATE_ENABLE 7
`define SWKCR_BIT_TRIM_HI 6
`define SWKCR_BIT_TRIM_LO 5
`define SWKCR_BIT_TO_MASK 4
`define SWKCR_BIT_CONFIG_VALID_FLAG 0
`define SWKCR_TRIM_UNLOCK 2'h3
`define SWKCR_CTRL_WMASK 8'hf1
`define SWKCR_CTRL_KEEP 8'hf0
`define SWKCR_SP_MASK 8'h3f
`endif

// File: hdl/swkcr_pkg.sv
// types shared by the register slice
package swkcr_pkg;
  typedef enum logic [1:0] {
    SWKCR_MODE_NORMAL,
    SWKCR_MODE_STOP,
    SWKCR_MODE_OTHER
  } swkcr_mode_t;
endpackage

// File: hdl/swkcr_sync.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/100ps
module swkcr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic rst_sync_b,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage_reg;
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      stage_reg <= '0;
      dout <= '0;
    end else begin
      stage_reg <= din;
      dout <= stage_reg;
    end
  end
endmodule

// File: hdl/swkcr_regs.sv
// selective wake configuration register slice
`timescale 1ns/100ps
`include "swkcr_defs.svh"
module swkcr_regs
  import swkcr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic soft_reset,
  input wire logic restart,
  input wire logic wake_event,
  input wire logic mode_normal,
  input wire logic mode_stop,
  input wire logic acc_strobe,
  input wire logic acc_write,
  input wire logic [6:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  input wire logic timeout_event,
  input wire logic transceiver_transmit_pin,
  output logic [7:0] acc_rdata,
  output logic [7:0] scratch_low_byte,
  output logic [7:0] scratch_high_byte,
  output logic oscillator_calibrate_enable,
  output logic trim_unlocked,
  output logic osc_ref_level,
  output logic option_write,
  output logic [7:0] option_wdata,
  output logic selective_wake_enable,
  output logic bus_timeout_flag,
  output logic interrupt_out_n,
  output logic [7:0] quanta_per_bit,
  output logic [5:0] sample_point_position,
  output logic [7:0] wake_ident_top_bits
);
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic txd_sync;
  logic [7:0] scr_lo_reg;
  logic [7:0] scr_hi_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] quanta_reg;
  logic [5:0] spoint_reg;
  logic [7:0] idtop_reg;
  logic [7:0] rdata_next;
  logic wr;
  logic cfg_write;
  logic unlocked;
  swkcr_mode_t mode;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  swkcr_sync #(.WIDTH(1)) u_txd_sync (
    .mclk(mclk),
    .rst_sync_b(rst_sync_reg),
    .din(transceiver_transmit_pin),
    .dout(txd_sync)
  );

  always_comb begin
    if (mode_normal) begin
      mode = SWKCR_MODE_NORMAL;
    end else if (mode_stop) begin
      mode = SWKCR_MODE_STOP;
    end else begin
      mode = SWKCR_MODE_OTHER;
    end
  end

  assign wr = acc_strobe && acc_write;
  assign unlocked = (ctrl_reg[`SWKCR_BIT_TRIM_HI:`SWKCR_BIT_TRIM_LO]
                     == `SWKCR_TRIM_UNLOCK);
  // any write to identifier, mask or length config, or timing
  assign cfg_write = wr && (((acc_addr >= `SWKCR_ADDR_QUANTA) &&
                   (acc_addr <= `SWKCR_ADDR_CFG_HI)));

  // scratch bytes: only power-on clears them
  always_ff @(posedge mclk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      scr_lo_reg <= `SWKCR_RST_SCR;
      scr_hi_reg <= `SWKCR_RST_SCR;
    end else if (wr && mode == SWKCR_MODE_NORMAL) begin
      // no soft reset or restart term here
      if (acc_addr == `SWKCR_ADDR_SCR_LO) begin
        scr_lo_reg <= acc_wdata;
      end
      if (acc_addr == `SWKCR_ADDR_SCR_HI) begin
        scr_hi_reg <= acc_wdata;
      end
    end
  end

  // wake control register
  always_ff @(posedge mclk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      ctrl_reg <= `SWKCR_RST_CTRL;
    end else if (soft_reset) begin
      ctrl_reg <= `SWKCR_RST_CTRL;
    end else if (restart) begin
      ctrl_reg <= ctrl_reg & `SWKCR_CTRL_KEEP;
    end else begin
      if (wr && acc_addr == `SWKCR_ADDR_CTRL) begin
        ctrl_reg <= acc_wdata & `SWKCR_CTRL_WMASK;
      end
      // hardware clear beats a same-cycle set, other bits still land
      if (wake_event || cfg_write) begin
        ctrl_reg[`SWKCR_BIT_CONFIG_VALID_FLAG] <= 1'b0;
      end
    end
  end

  // bit timing and identifier top byte
  always_ff @(posedge mclk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      quanta_reg <= `SWKCR_RST_QUANTA;
      spoint_reg <= 6'(`SWKCR_RST_SPOINT);
      idtop_reg <= `SWKCR_RST_IDTOP;
    end else if (soft_reset) begin
      quanta_reg <= `SWKCR_RST_QUANTA;
      spoint_reg <= 6'(`SWKCR_RST_SPOINT);
      idtop_reg <= `SWKCR_RST_IDTOP;
    end else if (wr) begin
      if (acc_addr == `SWKCR_ADDR_QUANTA) begin
        quanta_reg <= acc_wdata;
      end
      if (acc_addr == `SWKCR_ADDR_SPOINT) begin
        spoint_reg <= acc_wdata[5:0];
      end
      if (acc_addr == `SWKCR_ADDR_IDTOP) begin
        idtop_reg <= acc_wdata;
      end
    end
  end

  // read mux
  always_comb begin
    rdata_next = 8'h00;
    case (acc_addr)
      `SWKCR_ADDR_SCR_LO: begin
        if (mode != SWKCR_MODE_OTHER) begin
          rdata_next = scr_lo_reg;
        end
      end
      `SWKCR_ADDR_SCR_HI: begin
        if (mode != SWKCR_MODE_OTHER) begin
          rdata_next = scr_hi_reg;
        end
      end
      `SWKCR_ADDR_CTRL: rdata_next = ctrl_reg & `SWKCR_CTRL_WMASK;
      `SWKCR_ADDR_QUANTA: rdata_next = quanta_reg;
      `SWKCR_ADDR_SPOINT: rdata_next = {2'h0, spoint_reg};
      `SWKCR_ADDR_IDTOP: rdata_next = idtop_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      acc_rdata <= 8'h00;
    end else if (acc_strobe && !acc_write) begin
      acc_rdata <= rdata_next;
    end
  end

  // register copies to outputs
  always_ff @(posedge mclk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      scratch_low_byte <= 8'h00;
      scratch_high_byte <= 8'h00;
      oscillator_calibrate_enable <= 1'b0;
      trim_unlocked <= 1'b0;
      selective_wake_enable <= 1'b0;
      quanta_per_bit <= `SWKCR_RST_QUANTA;
      sample_point_position <= 6'(`SWKCR_RST_SPOINT);
      wake_ident_top_bits <= `SWKCR_RST_IDTOP;
    end else begin
      scratch_low_byte <= scr_lo_reg;
      scratch_high_byte <= scr_hi_reg;
      oscillator_calibrate_enable <= ctrl_reg[`SWKCR_BIT_OSCILLATOR_CALIBRATE_ENABLE];
      trim_unlocked <= unlocked;
      selective_wake_enable <= ctrl_reg[`SWKCR_BIT_CONFIG_VALID_FLAG];
      quanta_per_bit <= quanta_reg;
      sample_point_position <= spoint_reg;
      wake_ident_top_bits <= idtop_reg;
    end
  end

  // calibration reference taken from the transmit pin
  always_ff @(posedge mclk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      osc_ref_level <= 1'b0;
    end else if (ctrl_reg[`SWKCR_BIT_OSCILLATOR_CALIBRATE_ENABLE] && unlocked) begin
      osc_ref_level <= txd_sync;
    end else begin
      osc_ref_level <= 1'b0;
    end
  end

  // option register write pass-through
  always_ff @(posedge mclk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      option_write <= 1'b0;
      option_wdata <= 8'h00;
    end else begin
      option_write <= wr && (acc_addr == `SWKCR_ADDR_OPTION)
                      && unlocked;
      option_wdata <= acc_wdata;
    end
  end

  // bus time-out flag and interrupt
  always_ff @(posedge mclk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      bus_timeout_flag <= 1'b0;
      interrupt_out_n <= 1'b1;
    end else begin
      if (timeout_event && ctrl_reg[`SWKCR_BIT_CONFIG_VALID_FLAG]) begin
        bus_timeout_flag <= 1'b1;
      end else if (!ctrl_reg[`SWKCR_BIT_CONFIG_VALID_FLAG]) begin
        bus_timeout_flag <= 1'b0;
      end
      interrupt_out_n <= !(timeout_event && ctrl_reg[`SWKCR_BIT_CONFIG_VALID_FLAG]
                           && ctrl_reg[`SWKCR_BIT_TO_MASK]
                           && mode != SWKCR_MODE_OTHER);
    end
  end

  sequence s_scr_write;
    wr && acc_addr == `SWKCR_ADDR_SCR_LO && mode_normal;
  endsequence
  sequence s_scr_stored;
    ##1 scr_lo_reg == $past(acc_wdata)
    ##1 scratch_low_byte == $past(scr_lo_reg);
  endsequence
  sequence s_timeout_seen;
    timeout_event && ctrl_reg[`SWKCR_BIT_CONFIG_VALID_FLAG]
    && ctrl_reg[`SWKCR_BIT_TO_MASK] && (mode_normal || mode_stop);
  endsequence
  sequence s_irq_low;
    ##1 !interrupt_out_n;
  endsequence

  a_scratch_write: assert property (@(posedge mclk)
    disable iff (!rst_sync_reg) s_scr_write |-> s_scr_stored)
    else $error("scratch write not stored");
  a_scratch_blocked: assert property (@(posedge mclk)
    disable iff (!rst_sync_reg)
    !(wr && mode_normal) |=> $stable(scr_lo_reg) && $stable(scr_hi_reg))
    else $error("scratch changed without normal write");
  a_scratch_soft: assert property (@(posedge mclk)
    disable iff (!rst_sync_reg) soft_reset |=> $stable(scr_hi_reg))
    else $error("scratch lost on soft reset");
  a_scratch_hidden: assert property (@(posedge mclk)
    disable iff (!rst_sync_reg)
    (acc_strobe && !acc_write && acc_addr == `SWKCR_ADDR_SCR_LO
     && !mode_normal && !mode_stop) |=> acc_rdata == 8'h00)
    else $error("scratch readable outside normal and stop");
  a_trim_lock: assert property (@(posedge mclk)
    disable iff (!rst_sync_reg) option_write |-> $past(unlocked))
    else $error("option write while locked");
  a_option_pass: assert property (@(posedge mclk)
    disable iff (!rst_sync_reg)
    (wr && acc_addr == `SWKCR_ADDR_OPTION && unlocked)
    |=> option_write && option_wdata == $past(acc_wdata))
    else $error("unlocked option write lost");
  a_osc_enable: assert property (@(posedge mclk)
    disable iff (!rst_sync_reg)
    1'b1 |=> oscillator_calibrate_enable
    == $past(ctrl_reg[`SWKCR_BIT_OSCILLATOR_CALIBRATE_ENABLE]))
    else $error("calibration enable does not follow control");
  a_osc_locked: assert property (@(posedge mclk)
    disable iff (!rst_sync_reg)
    !(ctrl_reg[`SWKCR_BIT_OSCILLATOR_CALIBRATE_ENABLE] && unlocked) |=> !osc_ref_level)
    else $error("reference passed while locked");
  a_osc_track: assert property (@(posedge mclk)
    disable iff (!rst_sync_reg)
    (ctrl_reg[`SWKCR_BIT_OSCILLATOR_CALIBRATE_ENABLE] && unlocked)
    |=> osc_ref_level == $past(txd_sync))
    else $error("reference does not follow transmit pin");
  a_irq_gate: assert property (@(posedge mclk)
    disable iff (!rst_sync_reg)
    !interrupt_out_n |-> $past(ctrl_reg[`SWKCR_BIT_TO_MASK])
    && $past(ctrl_reg[`SWKCR_BIT_CONFIG_VALID_FLAG]))
    else $error("interrupt while masked");
  a_irq_signal: assert property (@(posedge mclk)
    disable iff (!rst_sync_reg) s_timeout_seen |-> s_irq_low)
    else $error("unmasked timeout not signalled");
  a_irq_mode: assert property (@(posedge mclk)
    disable iff (!rst_sync_reg)
    !interrupt_out_n |-> $past(mode_normal || mode_stop)
    && $past(timeout_event))
    else $error("interrupt outside normal and stop");
  a_flag_set: assert property (@(posedge mclk)
    disable iff (!rst_sync_reg)
    (timeout_event && ctrl_reg[`SWKCR_BIT_CONFIG_VALID_FLAG]) |=> bus_timeout_flag)
    else $error("timeout flag not set");
  a_flag_idle: assert property (@(posedge mclk)
    disable iff (!rst_sync_reg)
    !ctrl_reg[`SWKCR_BIT_CONFIG_VALID_FLAG] |=> !bus_timeout_flag)
    else $error("timeout flag set while wake disabled");
  a_cfg_clear: assert property (@(posedge mclk)
    disable iff (!rst_sync_reg)
    (wake_event && !soft_reset && !restart) |=>
    !ctrl_reg[`SWKCR_BIT_CONFIG_VALID_FLAG])
    else $error("valid flag kept after wake");
  a_cfg_change: assert property (@(posedge mclk)
    disable iff (!rst_sync_reg)
    (cfg_write && !soft_reset && !restart) |=>
    !ctrl_reg[`SWKCR_BIT_CONFIG_VALID_FLAG])
    else $error("valid flag kept after config change");
  a_restart_keep: assert property (@(posedge mclk)
    disable iff (!rst_sync_reg)
    (restart && !soft_reset) |=>
    ctrl_reg == ($past(ctrl_reg) & `SWKCR_CTRL_KEEP))
    else $error("restart control value wrong");
  a_soft_defaults: assert property (@(posedge mclk)
    disable iff (!rst_sync_reg)
    soft_reset |=> ctrl_reg == `SWKCR_RST_CTRL
    && quanta_reg == `SWKCR_RST_QUANTA && idtop_reg == `SWKCR_RST_IDTOP
    && spoint_reg == 6'(`SWKCR_RST_SPOINT))
    else $error("soft reset defaults wrong");
  a_reserved_zero: assert property (@(posedge mclk)
    disable iff (!rst_sync_reg)
    (ctrl_reg & ~`SWKCR_CTRL_WMASK) == 8'h00)
    else $error("reserved control bits set");
  a_sp_reserved: assert property (@(posedge mclk)
    disable iff (!rst_sync_reg)
    (acc_strobe && !acc_write && acc_addr == `SWKCR_ADDR_SPOINT)
    |=> (acc_rdata & ~`SWKCR_SP_MASK) == 8'h00)
    else $error("reserved sample point bits read back");
  a_wake_enable: assert property (@(posedge mclk)
    disable iff (!rst_sync_reg)
    selective_wake_enable |-> $past(ctrl_reg[`SWKCR_BIT_CONFIG_VALID_FLAG]))
    else $error("wake enabled without valid flag");
endmodule

// File: tb/swkcr_host.sv
// microcontroller model on the register access port
`timescale 1ns/100ps
module swkcr_host (
  input wire logic mclk,
  input wire logic [7:0] acc_rdata,
  input wire logic cal_on,
  output logic acc_strobe,
  output logic acc_write,
  output logic [6:0] acc_addr,
  output logic [7:0] acc_wdata,
  output logic transceiver_transmit_pin
);
  initial begin
    acc_strobe = 1'b0;
    acc_write = 1'b0;
    acc_addr = 7'h00;
    acc_wdata = 8'h00;
    transceiver_transmit_pin = 1'b1;
  end
  // one access; lines are scrambled once the access is taken
  task automatic xfer(input logic w, input logic [6:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk);
    acc_strobe <= 1'b1;
    acc_write <= w;
    acc_addr <= a;
    acc_wdata <= d;
    @(posedge mclk);
    acc_strobe <= 1'b0;
    acc_write <= 1'b0;
    acc_addr <= ~a;
    acc_wdata <= ~d;
    @(negedge mclk);
    q = acc_rdata;
  endtask
  // reference pattern while calibration is on, recessive otherwise
  always @(posedge mclk) begin
    transceiver_transmit_pin <= cal_on ? ~transceiver_transmit_pin : 1'b1;
  end
endmodule

// File: tb/tb_top.sv
// self-checking bench for the selective wake register slice
`timescale 1ns/100ps
module tb_top;
  logic mclk, rst_b, soft_reset, restart, wake_event, mode_normal;
  logic mode_stop, timeout_event, acc_strobe, acc_write, txd, osc_en;
  logic trim_ok, ref_lvl, ref_prev, opt_wr, swk_en, to_flag, irq_n;
  logic [6:0] acc_addr;
  logic [7:0] acc_wdata, acc_rdata, scr_lo, scr_hi, opt_wdata, quanta;
  logic [7:0] idtop, q, opt_last;
  logic [5:0] spoint;
  logic [7:0] tcase [4] = '{8'h11, 8'h01, 8'h10, 8'h11};
  int miscompares, checked, cycles, opt_cnt, irq_cnt, ref_cnt;
  swkcr_regs u_dut (.mclk(mclk), .rst_b(rst_b), .soft_reset(soft_reset),
    .restart(restart), .wake_event(wake_event), .mode_normal(mode_normal),
    .mode_stop(mode_stop), .acc_strobe(acc_strobe), .acc_write(acc_write),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .timeout_event(timeout_event), .transceiver_transmit_pin(txd),
    .acc_rdata(acc_rdata), .scratch_low_byte(scr_lo),
    .scratch_high_byte(scr_hi), .oscillator_calibrate_enable(osc_en),
    .trim_unlocked(trim_ok), .osc_ref_level(ref_lvl),
    .option_write(opt_wr), .option_wdata(opt_wdata),
    .selective_wake_enable(swk_en), .bus_timeout_flag(to_flag),
    .interrupt_out_n(irq_n), .quanta_per_bit(quanta),
    .sample_point_position(spoint), .wake_ident_top_bits(idtop));
  swkcr_host u_host (.mclk(mclk), .acc_rdata(acc_rdata), .cal_on(osc_en),
    .acc_strobe(acc_strobe), .acc_write(acc_write), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata), .transceiver_transmit_pin(txd));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic complete_run;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    u_host.xfer(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  task automatic settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    ref_prev <= ref_lvl;
    if (opt_wr === 1'b1) begin
      opt_cnt <= opt_cnt + 1;
      opt_last <= opt_wdata;
    end
    if (irq_n === 1'b0) irq_cnt <= irq_cnt + 1;
    if (ref_lvl !== ref_prev) ref_cnt <= ref_cnt + 1;
    if (cycles == 3000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    {soft_reset, restart, wake_event, mode_stop, timeout_event} = 5'h00;
    mode_normal = 1'b1;
    rst_b = 1'b0;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(7'h1e, 8'h00);
    rd(7'h1f, 8'h00);
    rd(7'h20, 8'h00);
    rd(7'h21, 8'ha0);
    rd(7'h22, 8'h33);
    rd(7'h23, 8'h00);
    chk(irq_n, 8'h01);
    wr(7'h1e, 8'h5a);
    wr(7'h1f, 8'hc3);
    settle();
    chk(scr_lo, 8'h5a);
    chk(scr_hi, 8'hc3);
    rd(7'h1f, 8'hc3);
    @(posedge mclk);
    mode_normal <= 1'b0;
    mode_stop <= 1'b1;
    wr(7'h1e, 8'h11);
    rd(7'h1e, 8'h5a);
    @(posedge mclk);
    mode_stop <= 1'b0;
    rd(7'h1e, 8'h00);
    @(posedge mclk);
    mode_normal <= 1'b1;
    wr(7'h21, 8'h55);
    wr(7'h22, 8'hff);
    wr(7'h23, 8'ha5);
    rd(7'h22, 8'h3f);
    settle();
    chk(spoint, 8'h3f);
    chk(quanta, 8'h55);
    chk(idtop, 8'ha5);
    @(posedge mclk);
    soft_reset <= 1'b1;
    @(posedge mclk);
    soft_reset <= 1'b0;
    rd(7'h1e, 8'h5a);
    rd(7'h1f, 8'hc3);
    rd(7'h21, 8'ha0);
    rd(7'h23, 8'h00);
    wr(7'h20, 8'hff);
    rd(7'h20, 8'hf1);
    settle();
    chk(swk_en, 8'h01);
    chk(trim_ok, 8'h01);
    @(posedge mclk);
    restart <= 1'b1;
    @(posedge mclk);
    restart <= 1'b0;
    rd(7'h20, 8'hf0);
    rd(7'h1e, 8'h5a);
    wr(7'h20, 8'hf1);
    wr(7'h21, 8'h20);
    settle();
    chk(swk_en, 8'h00);
    wr(7'h20, 8'hf1);
    @(posedge mclk);
    wake_event <= 1'b1;
    @(posedge mclk);
    wake_event <= 1'b0;
    rd(7'h20, 8'hf0);
    for (int i = 0; i < 4; i++) begin
      wr(7'h20, 8'(i << 5));
      #1 opt_cnt = 0;
      wr(7'h2c, 8'h77);
      settle();
      chk(8'(opt_cnt), (i == 3) ? 8'h01 : 8'h00);
      chk(trim_ok, (i == 3) ? 8'h01 : 8'h00);
      chk(osc_en, 8'h00);
    end
    chk(opt_last, 8'h77);
    for (int i = 0; i < 2; i++) begin
      wr(7'h20, i ? 8'he0 : 8'h80);
      settle();
      ref_cnt = 0;
      repeat (8) @(posedge mclk);
      #1 chk(8'(ref_cnt != 0), 8'(i));
      chk(osc_en, 8'h01);
    end
    for (int i = 0; i < 4; i++) begin
      wr(7'h20, tcase[i]);
      settle();
      irq_cnt = 0;
      @(posedge mclk);
      mode_normal <= (i != 3);
      timeout_event <= 1'b1;
      @(posedge mclk);
      timeout_event <= 1'b0;
      settle();
      chk(8'(irq_cnt != 0), (i == 0) ? 8'h01 : 8'h00);
      chk(to_flag, 8'(tcase[i][0]));
    end
    complete_run();
  end
endmodule
